// ===== shared/lane_fmt_pkg.sv
package lane_fmt_pkg;

    // operating format codes
    localparam logic [5:0] FMT_S8 = 6'h05;
    localparam logic [5:0] FMT_S16 = 6'h06;
    localparam logic [5:0] FMT_D8 = 6'h07;
    localparam logic [5:0] FMT_D16 = 6'h08;
    localparam logic [5:0] FMT_S4 = 6'h22;
    localparam logic [5:0] FMT_D4 = 6'h23;
    localparam logic [5:0] FMT_S8_C = 6'h2C;
    localparam logic [5:0] FMT_D8_C = 6'h2D;
    localparam logic [5:0] FMT_S16_C = 6'h32;
    localparam logic [5:0] FMT_D16_C = 6'h33;

    // lanes used per link
    localparam logic [3:0] NL_4 = 4'h2;
    localparam logic [3:0] NL_8 = 4'h4;
    localparam logic [3:0] NL_16 = 4'h8;
    localparam logic [3:0] NL_OFF = 4'h0;

    // test stream selection
    typedef enum logic [3:0] {
        TST_OFF, TST_PRBS7, TST_PRBS9, TST_PRBS15, TST_PRBS23, TST_PRBS31,
        TST_CLOCK, TST_RAMP, TST_SHORT, TST_D215, TST_K285, TST_ILA, TST_RJP
    } test_t;

    // prbs feedback taps
    localparam int PRBS7_A = 6;
    localparam int PRBS7_B = 7;
    localparam int PRBS9_A = 5;
    localparam int PRBS9_B = 9;
    localparam int PRBS15_A = 14;
    localparam int PRBS15_B = 15;
    localparam int PRBS23_A = 18;
    localparam int PRBS23_B = 23;
    localparam int PRBS31_A = 28;
    localparam int PRBS31_B = 31;
    localparam int PRBS_W = 31;

    // fixed characters
    localparam logic [7:0] OCT_ZERO = 8'h00;
    localparam logic [7:0] OCT_ONES = 8'hFF;
    localparam logic [7:0] OCT_D215 = 8'hB5;
    localparam logic [7:0] OCT_K285 = 8'hBC;

    // random jitter pattern, octet 0 in the low byte
    localparam logic [3:0] RJP_LEN = 4'hC;
    localparam logic [95:0] RJP_TAB = {
        8'h59, 8'h35, 8'hFB, 8'h5E, 8'h14, 8'hB3,
        8'h8F, 8'h6B, 8'h47, 8'h23, 8'hD7, 8'hBE
    };

endpackage

// ===== design/frame_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module frame_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic full_ff, nxt_full, empty_ff, nxt_empty;
    logic ready_ff, nxt_ready;
    logic push, pop;

    assign push = i_valid && !full_ff;
    assign pop = i_ready && !empty_ff;
    assign o_ready = ready_ff;
    assign o_valid = !empty_ff;
    assign o_data = mem_ff[rd_ff];

    always_comb begin
        nxt_wr = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
        nxt_rd = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_full = (nxt_cnt == (AW + 1)'(DEPTH));
        nxt_empty = (nxt_cnt == '0);
        nxt_ready = !nxt_full;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
            ready_ff <= 1'b1;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            full_ff <= nxt_full;
            empty_ff <= nxt_empty;
            ready_ff <= nxt_ready;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= i_data;
        end
    end

endmodule // frame_fifo

`default_nettype wire

// ===== design/serial_lane_formatter.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - 8-lane dual: A[k] to lane Ak, B[k] Bk
// - 16-lane dual: A[k], B[k] on lanes k
// - format 50 maps like other 16-lane single
// - single: even samples link A, odd B
// - 4-lane single: S0 A0, S2 A1, S1 B0, S3 B1
// - 4-lane dual: A0,A1 and B0,B1 lanes
// - offset binary octets MSB first, tails zero
// - lowest lanes used, upper lanes powered down
// - sync header CRC-12 or FEC, no CRC-3
// - power-down disables every lane driver
// - test select picks stream, format sets lanes
// - PRBS raw, unscrambled, distinct lane phases
// - PRBS7 taps 6,7 and PRBS9 taps 5,9
// - PRBS15, PRBS23, PRBS31 long sequences
// - clock pattern eight ones, eight zeros, raw
// - ramp counter 00 to FF on every lane
// - ramp starts after alignment or serdes init
// - short transport: k then FF minus k
// - D21.5 stream in both codings
// - K28.5 comma stream, 8b/10b only
// - repeated ILA, resync on receiver request
// - jitter pattern 12 octets, 8b/10b only
// - jitter pattern octet values in order
module serial_lane_formatter #(
    parameter int LANES = 8,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // configuration
    input wire logic [5:0] i_link_format_select,
    input wire logic [3:0] i_lane_test_select,
    input wire logic i_sync_hdr_fec,
    input wire logic i_power_down_pin,
    // link layer status
    input wire logic i_ila_done,
    input wire logic i_serdes_init,
    input wire logic i_sync_n,
    input wire logic i_lane_ready,
    // sample frames
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire logic [2*LANES*8-1:0] i_smp_frame,
    // lane outputs
    output logic [LANES*8-1:0] o_lane_a_data,
    output logic [LANES*8-1:0] o_lane_b_data,
    output logic [2*LANES-1:0] o_lane_ctrl_k,
    output logic [2*LANES-1:0] o_lane_drv_en,
    output logic o_lane_valid,
    output logic o_lane_raw,
    output logic o_sync_hdr_fec,
    output logic o_ila_repeat,
    output logic o_cgs_start
);

    localparam int NL = 2 * LANES;
    localparam int FW = NL * 8;

    lane_fmt_pkg::test_t tsel, mode_ff;
    logic [3:0] nlanes;
    logic dual, is_64b, is_prbs, run_data, step, f_valid, f_pop;
    logic [FW-1:0] f_data;
    int tap_a, tap_b;

    assign tsel = lane_fmt_pkg::test_t'(i_lane_test_select);

    ////////////////////////////////////////////////////////////////////
    // format decode

    always_comb begin
        nlanes = lane_fmt_pkg::NL_OFF;
        dual = 1'b0;
        is_64b = 1'b0;
        case (i_link_format_select)
            lane_fmt_pkg::FMT_S4: nlanes = lane_fmt_pkg::NL_4;
            lane_fmt_pkg::FMT_D4: begin
                nlanes = lane_fmt_pkg::NL_4;
                dual = 1'b1;
            end
            lane_fmt_pkg::FMT_S8: nlanes = lane_fmt_pkg::NL_8;
            lane_fmt_pkg::FMT_D8: begin
                nlanes = lane_fmt_pkg::NL_8;
                dual = 1'b1;
            end
            lane_fmt_pkg::FMT_S16: nlanes = lane_fmt_pkg::NL_16;
            lane_fmt_pkg::FMT_D16: begin
                nlanes = lane_fmt_pkg::NL_16;
                dual = 1'b1;
            end
            lane_fmt_pkg::FMT_S8_C: begin
                nlanes = lane_fmt_pkg::NL_8;
                is_64b = 1'b1;
            end
            lane_fmt_pkg::FMT_D8_C: begin
                nlanes = lane_fmt_pkg::NL_8;
                dual = 1'b1;
                is_64b = 1'b1;
            end
            lane_fmt_pkg::FMT_S16_C: begin
                nlanes = lane_fmt_pkg::NL_16;
                is_64b = 1'b1;
            end
            lane_fmt_pkg::FMT_D16_C: begin
                nlanes = lane_fmt_pkg::NL_16;
                dual = 1'b1;
                is_64b = 1'b1;
            end
            default: nlanes = lane_fmt_pkg::NL_OFF;
        endcase
    end

    always_comb begin
        tap_a = lane_fmt_pkg::PRBS7_A;
        tap_b = lane_fmt_pkg::PRBS7_B;
        is_prbs = 1'b1;
        case (tsel)
            lane_fmt_pkg::TST_PRBS7: tap_a = lane_fmt_pkg::PRBS7_A;
            lane_fmt_pkg::TST_PRBS9: begin
                tap_a = lane_fmt_pkg::PRBS9_A;
                tap_b = lane_fmt_pkg::PRBS9_B;
            end
            lane_fmt_pkg::TST_PRBS15: begin
                tap_a = lane_fmt_pkg::PRBS15_A;
                tap_b = lane_fmt_pkg::PRBS15_B;
            end
            lane_fmt_pkg::TST_PRBS23: begin
                tap_a = lane_fmt_pkg::PRBS23_A;
                tap_b = lane_fmt_pkg::PRBS23_B;
            end
            lane_fmt_pkg::TST_PRBS31: begin
                tap_a = lane_fmt_pkg::PRBS31_A;
                tap_b = lane_fmt_pkg::PRBS31_B;
            end
            default: is_prbs = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sample buffer

    assign run_data = !i_power_down_pin && (tsel == lane_fmt_pkg::TST_OFF) &&
        (nlanes != lane_fmt_pkg::NL_OFF);
    assign f_pop = run_data && f_valid && i_lane_ready;
    assign step = i_lane_ready && !i_power_down_pin;

    frame_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_valid(i_smp_valid),
        .o_ready(o_smp_ready),
        .i_data(i_smp_frame),
        .o_valid(f_valid),
        .i_ready(f_pop),
        .o_data(f_data)
    );

    ////////////////////////////////////////////////////////////////////
    // pattern state

    localparam int PRBS_WL = lane_fmt_pkg::PRBS_W;

    // advance one octet of y[n] = y[n-a] ^ y[n-b], first bit in bit 7
    function automatic logic [PRBS_WL+7:0] prbs_adv(input logic [PRBS_WL-1:0] s,
                                                    input int a, input int b);
        logic [PRBS_WL-1:0] st;
        logic [7:0] oct;
        logic nb;
        st = s;
        oct = '0;
        for (int i = 0; i < 8; i++) begin
            nb = st[a-1] ^ st[b-1];
            oct[7-i] = nb;
            st = {st[PRBS_WL-2:0], nb};
        end
        return {st, oct};
    endfunction

    logic [PRBS_WL-1:0] prbs_ff [NL];
    logic [PRBS_WL-1:0] nxt_prbs [NL];
    logic [FW-1:0] lane_ff, nxt_lane;
    logic [NL-1:0] k_ff, nxt_k, en_ff, nxt_en;
    logic [7:0] ramp_ff, nxt_ramp;
    logic [3:0] rjp_ff, nxt_rjp;
    logic phase_ff, nxt_phase, ramp_go_ff, nxt_ramp_go;
    logic valid_ff, nxt_valid, raw_ff, nxt_raw;
    logic fec_ff, nxt_fec, ila_ff, nxt_ila, cgs_ff, nxt_cgs, sync_d_ff;
    logic [PRBS_WL+7:0] adv;
    logic [7:0] oct, kk;
    logic pat_ok;

    always_comb begin
        nxt_lane = lane_ff;
        nxt_k = k_ff;
        nxt_en = '0;
        nxt_prbs = prbs_ff;
        nxt_ramp = ramp_ff;
        nxt_rjp = rjp_ff;
        nxt_phase = phase_ff;
        nxt_ramp_go = ramp_go_ff;
        adv = '0;
        oct = '0;
        kk = '0;
        pat_ok = 1'b1;
        case (tsel)
            lane_fmt_pkg::TST_K285, lane_fmt_pkg::TST_ILA,
            lane_fmt_pkg::TST_RJP: pat_ok = !is_64b;
            lane_fmt_pkg::TST_RAMP: pat_ok = ramp_go_ff;
            lane_fmt_pkg::TST_OFF: pat_ok = f_pop;
            default: pat_ok = 1'b1;
        endcase
        nxt_valid = !i_power_down_pin && pat_ok && (tsel == lane_fmt_pkg::TST_OFF ||
            (i_lane_ready && nlanes != lane_fmt_pkg::NL_OFF));
        nxt_raw = is_prbs || tsel == lane_fmt_pkg::TST_CLOCK;
        for (int l = 0; l < NL; l++) begin
            kk = 8'(l % LANES);
            nxt_en[l] = !i_power_down_pin && (kk < 8'(nlanes));
            adv = prbs_adv(prbs_ff[l], tap_a, tap_b);
            oct = lane_fmt_pkg::OCT_ZERO;
            case (tsel)
                lane_fmt_pkg::TST_OFF: begin
                    if (dual) begin
                        oct = f_data[8*l+:8];
                    end else begin
                        oct = f_data[8*(2*(l % LANES) + l / LANES)+:8];
                    end
                end
                lane_fmt_pkg::TST_CLOCK: oct = phase_ff ? lane_fmt_pkg::OCT_ZERO :
                    lane_fmt_pkg::OCT_ONES;
                lane_fmt_pkg::TST_RAMP: oct = ramp_ff;
                lane_fmt_pkg::TST_SHORT: oct = phase_ff ? ~kk : kk;
                lane_fmt_pkg::TST_D215: oct = lane_fmt_pkg::OCT_D215;
                lane_fmt_pkg::TST_K285: oct = lane_fmt_pkg::OCT_K285;
                lane_fmt_pkg::TST_RJP: oct = lane_fmt_pkg::RJP_TAB[8*rjp_ff+:8];
                default: oct = is_prbs ? adv[7:0] : lane_fmt_pkg::OCT_ZERO;
            endcase
            if (!is_prbs || mode_ff != tsel) begin
                nxt_prbs[l] = PRBS_WL'(l + 1);
            end else if (step) begin
                nxt_prbs[l] = adv[PRBS_WL+7:8];
            end
            if (!nxt_en[l] || !pat_ok) begin
                oct = lane_fmt_pkg::OCT_ZERO;
            end
            if (nxt_valid || !nxt_en[l]) begin
                nxt_lane[8*l+:8] = oct;
                nxt_k[l] = nxt_en[l] && pat_ok && tsel == lane_fmt_pkg::TST_K285;
            end
        end
        if (mode_ff != tsel) begin
            nxt_ramp = lane_fmt_pkg::OCT_ZERO;
            nxt_rjp = '0;
            nxt_phase = 1'b0;
            nxt_ramp_go = 1'b0;
        end else if (nxt_valid) begin
            nxt_phase = !phase_ff;
            nxt_ramp = ramp_ff + 8'h01;
            nxt_rjp = (rjp_ff == lane_fmt_pkg::RJP_LEN - 4'h1) ? 4'h0 : rjp_ff + 4'h1;
        end
        if (tsel == lane_fmt_pkg::TST_RAMP && (is_64b ? i_serdes_init : i_ila_done)) begin
            nxt_ramp_go = mode_ff == tsel;
        end
        if (i_power_down_pin) begin
            nxt_ramp_go = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link control

    always_comb begin
        nxt_fec = i_sync_hdr_fec;
        nxt_ila = !is_64b && tsel == lane_fmt_pkg::TST_ILA && !i_power_down_pin;
        nxt_cgs = nxt_ila && sync_d_ff && !i_sync_n;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            lane_ff <= '0;
            k_ff <= '0;
            en_ff <= '0;
            ramp_ff <= '0;
            rjp_ff <= '0;
            phase_ff <= 1'b0;
            ramp_go_ff <= 1'b0;
            valid_ff <= 1'b0;
            raw_ff <= 1'b0;
            fec_ff <= 1'b0;
            ila_ff <= 1'b0;
            cgs_ff <= 1'b0;
            sync_d_ff <= 1'b1;
            mode_ff <= lane_fmt_pkg::TST_OFF;
            for (int l = 0; l < NL; l++) begin
                prbs_ff[l] <= PRBS_WL'(l + 1);
            end
        end else begin
            lane_ff <= nxt_lane;
            k_ff <= nxt_k;
            en_ff <= nxt_en;
            ramp_ff <= nxt_ramp;
            rjp_ff <= nxt_rjp;
            phase_ff <= nxt_phase;
            ramp_go_ff <= nxt_ramp_go;
            valid_ff <= nxt_valid;
            raw_ff <= nxt_raw;
            fec_ff <= nxt_fec;
            ila_ff <= nxt_ila;
            cgs_ff <= nxt_cgs;
            sync_d_ff <= i_sync_n;
            mode_ff <= tsel;
            prbs_ff <= nxt_prbs;
        end
    end

    assign o_lane_a_data = lane_ff[FW/2-1:0];
    assign o_lane_b_data = lane_ff[FW-1:FW/2];
    assign o_lane_ctrl_k = k_ff;
    assign o_lane_drv_en = en_ff;
    assign o_lane_valid = valid_ff;
    assign o_lane_raw = raw_ff;
    assign o_sync_hdr_fec = fec_ff;
    assign o_ila_repeat = ila_ff;
    assign o_cgs_start = cgs_ff;

    ////////////////////////////////////////////////////////////////////
    // checks

    logic steady;
    // mode_ff holds last cycle's select, so equality already means a stable select
    assign steady = mode_ff == tsel && !i_power_down_pin;

    a_pd_drivers_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_power_down_pin |=> o_lane_drv_en == '0 && !o_lane_valid)
        else $error("lane drivers active in power-down");
    a_upper_lanes_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (nlanes == lane_fmt_pkg::NL_4) |=> o_lane_drv_en[LANES-1:2] == '0)
        else $error("upper lane enabled in 4-lane format");
    a_fec_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ##1 o_sync_hdr_fec == $past(i_sync_hdr_fec))
        else $error("sync header mode not applied");
    a_single_map: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        f_pop && !dual |=> o_lane_b_data[7:0] == $past(f_data[15:8]) &&
        o_lane_a_data[15:8] == $past(f_data[23:16]))
        else $error("single channel sample placed on wrong lane");
    a_dual_map: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        f_pop && dual |=> o_lane_b_data[7:0] == $past(f_data[FW/2+7:FW/2]))
        else $error("channel B sample 0 not on lane B0");
    a_clock_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        tsel == lane_fmt_pkg::TST_CLOCK && steady && o_lane_valid && nxt_valid
        |=> o_lane_a_data[7:0] == ~$past(o_lane_a_data[7:0]) && o_lane_raw)
        else $error("clock pattern did not alternate");
    a_ramp_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        tsel == lane_fmt_pkg::TST_RAMP && steady && o_lane_valid && nxt_valid
        |=> o_lane_a_data[7:0] == $past(o_lane_a_data[7:0]) + 8'h01 &&
        o_lane_b_data[7:0] == o_lane_a_data[7:0])
        else $error("ramp did not count on every lane");
    a_ramp_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        tsel == lane_fmt_pkg::TST_RAMP && !ramp_go_ff |=> !o_lane_valid)
        else $error("ramp sent before link start");
    a_short_lane1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        tsel == lane_fmt_pkg::TST_SHORT && steady && nxt_valid && nlanes != lane_fmt_pkg::NL_OFF
        |=> (o_lane_a_data[15:8] == 8'h01) ^ (o_lane_a_data[15:8] == 8'hFE))
        else $error("short transport octet wrong on lane 1");
    a_k_comma: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        tsel == lane_fmt_pkg::TST_K285 && !is_64b && nxt_valid
        |=> o_lane_ctrl_k[0] && o_lane_a_data[7:0] == lane_fmt_pkg::OCT_K285)
        else $error("comma stream missing");
    a_rjp_next: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        tsel == lane_fmt_pkg::TST_RJP && steady && o_lane_valid && nxt_valid &&
        o_lane_a_data[7:0] == 8'hBE |=> o_lane_a_data[7:0] == 8'hD7)
        else $error("jitter pattern out of order");
    a_prbs_raw: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        is_prbs |=> o_lane_raw ##0 (o_lane_a_data[7:0] != o_lane_a_data[15:8] ||
        !o_lane_valid || nlanes == lane_fmt_pkg::NL_OFF))
        else $error("prbs lanes not raw or in phase");

    c_data_mode: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        f_pop ##1 f_pop);
    c_ramp_wrap: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_lane_valid && o_lane_a_data[7:0] == 8'hFF && tsel == lane_fmt_pkg::TST_RAMP);
    c_cgs: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_cgs_start);
    c_fifo_full: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !o_smp_ready);

endmodule // serial_lane_formatter

`default_nettype wire

// ===== dv/lane_rx_model.sv
`timescale 1ns/100ps
`default_nettype none

// far-side receiver: paces the lanes and raises sync requests
module lane_rx_model (
    // clock
    input wire logic i_ref_clk,
    // bench control
    input wire logic i_stall,
    input wire logic i_req_sync,
    // link side
    output logic o_lane_ready,
    output logic o_sync_n
);
    // stall models a disabled link: o_lane_ready drops at the next rising edge
    // outputs move just after the rising edge, so the bench's falling-edge control never races
    initial begin
        o_lane_ready = 1'b0;
        o_sync_n = 1'b1;
        forever begin
            @(posedge i_ref_clk);
            o_lane_ready <= !i_stall;
            o_sync_n <= !i_req_sync;
        end
    end
endmodule // lane_rx_model

`default_nettype wire

// ===== dv/serial_lane_formatter_test.sv
`timescale 1ns/100ps
`default_nettype none

module serial_lane_formatter_test;
    logic clk, rstn, fec, pd, ila, sinit, stall, req, sv, srdy, lval, raw, ofec, ilar, cgs;
    logic lrdy, syncn;
    logic [5:0] fmt;
    logic [3:0] tst;
    logic [127:0] fr;
    logic [63:0] la, lb;
    logic [15:0] ck, den;
    int n_fail, check_count;
    localparam logic [5:0] D8 = lane_fmt_pkg::FMT_D8;

    lane_rx_model u_rx (.i_ref_clk(clk), .i_stall(stall), .i_req_sync(req),
        .o_lane_ready(lrdy), .o_sync_n(syncn));

    serial_lane_formatter u_dut (.i_ref_clk(clk), .i_rstn(rstn),
        .i_link_format_select(fmt), .i_lane_test_select(tst), .i_sync_hdr_fec(fec),
        .i_power_down_pin(pd), .i_ila_done(ila), .i_serdes_init(sinit),
        .i_sync_n(syncn), .i_lane_ready(lrdy), .i_smp_valid(sv), .o_smp_ready(srdy),
        .i_smp_frame(fr), .o_lane_a_data(la), .o_lane_b_data(lb), .o_lane_ctrl_k(ck),
        .o_lane_drv_en(den), .o_lane_valid(lval), .o_lane_raw(raw),
        .o_sync_hdr_fec(ofec), .o_ila_repeat(ilar), .o_cgs_start(cgs));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wait_valid;
        int w;
        w = 0;
        while (lval !== 1'b1 && w < 20) begin
            @(negedge clk);
            w++;
        end
        cmp(64'(w < 20), 64'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // every format: sample to lane layout, driver enables, sync header choice
    task automatic t_map;
        logic [5:0] fl[10] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h22, 6'h23, 6'h2C, 6'h2D,
            6'h32, 6'h33};
        int nlt[10] = '{4, 8, 4, 8, 2, 2, 4, 4, 8, 8};
        bit dt[10] = '{0, 0, 1, 1, 0, 1, 0, 1, 0, 1};
        logic [63:0] ea, eb;
        logic [15:0] en;
        for (int i = 0; i < 10; i++) begin
            fmt = fl[i];
            fec = i[0];
            for (int n = 0; n < 16; n++)
                fr[8*n+:8] = 8'(8'h10 * n + i + 1);
            sv = 1'b1;
            @(negedge clk);
            sv = 1'b0;
            wait_valid();
            {ea, eb, en} = '0;
            for (int k = 0; k < nlt[i]; k++) begin
                ea[8*k+:8] = dt[i] ? fr[8*k+:8] : fr[16*k+:8];
                eb[8*k+:8] = dt[i] ? fr[64+8*k+:8] : fr[16*k+8+:8];
                en[k] = 1'b1;
                en[8+k] = 1'b1;
            end
            cmp(la, ea);
            cmp(lb, eb);
            cmp(64'(den), 64'(en));
            cmp(64'(ofec), 64'(fec));
        end
        $display("format mapping done");
    endtask

    task automatic t_pd;
        pd = 1'b1;
        repeat (2) @(negedge clk);
        cmp(64'(den), 64'h0);
        cmp(64'(lval), 64'h0);
        pd = 1'b0;
        $display("power down done");
    endtask

    // fill the buffer against a stalled receiver, then drain it
    task automatic t_fifo;
        int n, m;
        {n, m} = '0;
        stall = 1'b1;
        repeat (2) @(negedge clk);
        sv = 1'b1;
        repeat (12) begin
            if (srdy === 1'b1)
                n++;
            @(negedge clk);
        end
        sv = 1'b0;
        cmp(64'(n), 64'h8);
        stall = 1'b0;
        repeat (24) begin
            @(negedge clk);
            if (lval === 1'b1)
                m++;
        end
        cmp(64'(m), 64'h8);
        $display("buffer fill and drain done");
    endtask

    // select a test stream while the link is held down
    task automatic pick(input logic [3:0] t);
        stall = 1'b1;
        repeat (3) @(negedge clk);
        tst = t;
        fmt = D8;
        repeat (2) @(negedge clk);
        stall = 1'b0;
    endtask

    task automatic t_pat;
        logic [7:0] rj[12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14,
            8'h5E, 8'hFB, 8'h35, 8'h59};
        logic [3:0] tl[6] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC};
        logic [7:0] e;
        for (int i = 0; i < 6; i++) begin
            pick(tl[i]);
            for (int j = 0; j < 12; j++) begin
                wait_valid();
                case (i)
                    0: e = j[0] ? 8'h00 : 8'hFF;
                    1: e = 8'(j);
                    2: e = j[0] ? 8'hFF : 8'h00;
                    3: e = 8'hB5;
                    4: e = 8'hBC;
                    default: e = rj[j];
                endcase
                cmp(64'(la[7:0]), 64'(e));
                if (i == 2)
                    cmp(64'(la[31:24]), 64'(j[0] ? 8'hFC : 8'h03));
                cmp(64'(ck[0]), 64'(i == 4));
                cmp(64'(raw), 64'(i == 0));
                @(negedge clk);
            end
        end
        $display("pattern streams done");
    endtask

    task automatic t_prbs;
        logic [31:0] b;
        int ta[2] = '{6, 5};
        int tb[2] = '{7, 9};
        int bad;
        for (int i = 0; i < 2; i++) begin
            pick(4'(i + 1));
            bad = 0;
            for (int j = 0; j < 4; j++) begin
                wait_valid();
                b[31-8*j-:8] = la[7:0];
                if (j == 0)
                    cmp(64'(la[7:0] === la[15:8]), 64'h0);
                cmp(64'(raw), 64'h1);
                @(negedge clk);
            end
            for (int n = tb[i]; n < 32; n++)
                if (b[31-n] !== (b[31-n+ta[i]] ^ b[31-n+tb[i]]))
                    bad++;
            cmp(64'(bad), 64'h0);
        end
        $display("prbs done");
    endtask

    task automatic t_ila;
        int w;
        pick(4'hB);
        repeat (2) @(negedge clk);
        cmp(64'(ilar), 64'h1);
        req = 1'b1;
        w = 0;
        while (cgs !== 1'b1 && w < 6) begin
            @(negedge clk);
            w++;
        end
        cmp(64'(w < 6), 64'h1);
        req = 1'b0;
        pick(4'h0);
        $display("repeated alignment done");
    endtask

    // 64b/66b ramp waits for serializer init, not for the alignment sequence
    task automatic t_ramp64;
        ila = 1'b0;
        pick(4'h7);
        fmt = lane_fmt_pkg::FMT_S8_C;
        repeat (4) @(negedge clk);
        cmp(64'(lval), 64'h0);
        sinit = 1'b1;
        wait_valid();
        cmp(64'(la[7:0]), 64'h0);
        @(negedge clk);
        cmp(64'(la[7:0]), 64'h1);
        sinit = 1'b0;
        ila = 1'b1;
        $display("serializer ramp start done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, fec, pd, sinit, stall, req, sv, n_fail, check_count} = '0;
        ila = 1'b1;
        fmt = D8;
        tst = 4'h0;
        fr = '0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        t_map();
        t_pd();
        t_fifo();
        t_pat();
        t_prbs();
        t_ila();
        t_ramp64();
        end_sim();
    end

    initial begin
        #30000;
        n_fail++;
        end_sim();
    end
endmodule // serial_lane_formatter_test

`default_nettype wire
